// >>> rtl/ccu_top.sv
// Purpose: two capture/compare units with four time-base timers
// Assumes: gen_timer_ovf is a one-cycle pulse on clk_sys
// Notes:   registers over avalon-mm, one word per register
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ccu_map.svh"
module ccu_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // count sources
  input  wire logic        gen_timer_ovf,
  input  wire logic [1:0]  ext_count_in,
  // channel pins
  input  wire logic [31:0] cc_pin_in,
  output logic      [31:0] cc_pin_out,
  output logic      [31:0] cc_pin_oe,
  // per-channel interrupt requests
  output logic      [31:0] irq_req
);
  ccu_pkg::ccu_state_s st;
  ccu_pkg::ccu_state_s next_st;
  logic [3:0]  tick;
  logic [3:0]  ovf;
  logic [31:0] cap_evt;
  logic [31:0] cmp_hit;
  logic [1:0]  ext_rise;
  logic [10:0] pmask;
  logic [1:0]  tb;
  logic [15:0] tcur;
  logic        rise;
  logic        fall;
  logic [7:0]  idx;
  logic        req;

  // merge a 16-bit write under its two byte lanes
  function automatic logic [15:0] ccu_merge16(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0]  be
  );
    ccu_merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
                   be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole block
  always_comb begin
    next_st  = st;
    tick     = '0;
    ovf      = '0;
    cap_evt  = '0;
    cmp_hit  = '0;
    pmask    = '0;
    tb       = '0;
    tcur     = '0;
    rise     = 1'b0;
    fall     = 1'b0;
    idx      = avs_address[9:2];
    req      = avs_read | avs_write;
    // two-stage synchronisers, third stage only for edges
    next_st.sync1    = cc_pin_in;
    next_st.sync2    = st.sync1;
    next_st.prev     = st.sync2;
    next_st.ext_s1   = ext_count_in;
    next_st.ext_s2   = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    ext_rise = st.ext_s2 & ~st.ext_prev;
    next_st.pre  = st.pre + 10'h001;
    next_st.chg  = '0;
    next_st.ovfd = '0;

    // four up-counting time bases
    for (int t = 0; t < 4; t++) begin
      pmask = (`CCU_PRESC_BASE << st.tmr[t].ctl.psel) - 11'h001;
      case (st.tmr[t].ctl.src)
        `CCU_SRC_PRESC: tick[t] = ({1'b0, st.pre} & pmask) == pmask;
        `CCU_SRC_GEN:   tick[t] = gen_timer_ovf;
        `CCU_SRC_EXT:   tick[t] = (t % 2 == 0) ? ext_rise[t / 2] : 1'b0;
        default:        tick[t] = 1'b0;
      endcase
      tick[t] = tick[t] & st.tmr[t].ctl.run;
      if (tick[t]) begin
        next_st.chg[t] = 1'b1;
        if (st.tmr[t].cnt == `CCU_CNT_MAX) begin
          ovf[t] = 1'b1;
          next_st.ovfd[t] = 1'b1;
          next_st.tmr[t].cnt = st.tmr[t].rld;
        end else begin
          next_st.tmr[t].cnt = st.tmr[t].cnt + 16'h0001;
        end
      end
    end

    // avalon slave: one wait cycle, write lands on the ack edge
    next_st.ack = req & ~st.ack;
    if (avs_read && !st.ack) begin
      next_st.rdata = 32'h0000_0000;
      if (idx < `CCU_IDX_VAL)
        next_st.rdata[7:0] = st.cfg[idx[4:0]];
      else if (idx < `CCU_IDX_CNT)
        next_st.rdata[15:0] = st.val[idx[4:0]];
      else if (idx < `CCU_IDX_RLD)
        next_st.rdata[15:0] = st.tmr[idx[1:0]].cnt;
      else if (idx < `CCU_IDX_TCTL)
        next_st.rdata[15:0] = st.tmr[idx[1:0]].rld;
      else if (idx < `CCU_IDX_PIN)
        next_st.rdata[5:0] = st.tmr[idx[1:0]].ctl;
      else if (idx == `CCU_IDX_PIN)
        next_st.rdata = st.pin & `CCU_OUT_MASK;
    end
    if (avs_write && st.ack) begin
      if (idx < `CCU_IDX_VAL) begin
        if (avs_byteenable[0])
          next_st.cfg[idx[4:0]] = avs_writedata[7:0];
      end else if (idx < `CCU_IDX_CNT) begin
        next_st.val[idx[4:0]] = ccu_merge16(st.val[idx[4:0]],
          avs_writedata[15:0], avs_byteenable[1:0]);
      end else if (idx < `CCU_IDX_RLD) begin
        next_st.tmr[idx[1:0]].cnt = ccu_merge16(st.tmr[idx[1:0]].cnt,
          avs_writedata[15:0], avs_byteenable[1:0]);
      end else if (idx < `CCU_IDX_TCTL) begin
        next_st.tmr[idx[1:0]].rld = ccu_merge16(st.tmr[idx[1:0]].rld,
          avs_writedata[15:0], avs_byteenable[1:0]);
      end else if (idx < `CCU_IDX_PIN) begin
        if (avs_byteenable[0])
          next_st.tmr[idx[1:0]].ctl = avs_writedata[5:0];
      end
    end

    // channels: events applied after bus writes so a set wins
    for (int c = 0; c < 32; c++) begin
      tb   = {1'(c / 16), st.cfg[c].tsel};
      tcur = st.tmr[tb].cnt;
      rise = st.sync2[c] & ~st.prev[c];
      fall = ~st.sync2[c] & st.prev[c];
      // equality checked each time the timer ticks, not after a bus write to the count
      cmp_hit[c] = st.chg[tb] && (st.val[c] == tcur);
      if (st.cfg[c].mode == ccu_pkg::CCU_DBL && (c % 16) < `CCU_DBL_SPAN)
        cmp_hit[c] = cmp_hit[c] ||
          (st.chg[tb] && st.val[(c + `CCU_DBL_SPAN) % 32] == tcur);
      if (st.ovfd[tb])
        next_st.done[c] = 1'b0;
      case (st.cfg[c].mode)
        ccu_pkg::CCU_CAP: begin
          cap_evt[c] = (st.cfg[c].edge_sel[0] & rise) |
                       (st.cfg[c].edge_sel[1] & fall);
          if (cap_evt[c]) begin
            next_st.val[c] = tcur;
            next_st.cfg[c].flag = 1'b1;
          end
        end
        ccu_pkg::CCU_CMP0: begin
          if (cmp_hit[c])
            next_st.cfg[c].flag = 1'b1;
        end
        ccu_pkg::CCU_CMP1: begin
          if (cmp_hit[c]) begin
            next_st.pin[c] = ~st.pin[c];
            next_st.cfg[c].flag = 1'b1;
          end
        end
        ccu_pkg::CCU_CMP2: begin
          // a match on the reload value opens a new period, so it counts
          if (cmp_hit[c] && (!st.done[c] || st.ovfd[tb])) begin
            next_st.cfg[c].flag = 1'b1;
            next_st.done[c] = 1'b1;
          end
        end
        ccu_pkg::CCU_CMP3: begin
          if (st.ovfd[tb])
            next_st.pin[c] = 1'b0;
          // set wins over the overflow clear in the same cycle
          if (cmp_hit[c] && (!st.done[c] || st.ovfd[tb])) begin
            next_st.pin[c] = 1'b1;
            next_st.done[c] = 1'b1;
            next_st.cfg[c].flag = 1'b1;
          end
        end
        ccu_pkg::CCU_DBL: begin
          if (cmp_hit[c]) begin
            next_st.pin[c] = ~st.pin[c];
            next_st.cfg[c].flag = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_waitrequest = req & ~st.ack;
  assign avs_readdata    = st.rdata;
  assign cc_pin_out      = st.pin & `CCU_OUT_MASK;
  // pin driven only in modes that act on it
  always_comb begin
    cc_pin_oe = '0;
    irq_req   = '0;
    for (int c = 0; c < 32; c++) begin
      cc_pin_oe[c] = st.cfg[c].mode == ccu_pkg::CCU_CMP1 ||
                     st.cfg[c].mode == ccu_pkg::CCU_CMP3 ||
                     st.cfg[c].mode == ccu_pkg::CCU_DBL;
      irq_req[c] = st.cfg[c].flag & st.cfg[c].ien;
    end
    cc_pin_oe = cc_pin_oe & `CCU_OUT_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_cap_latch: assert property (
    cap_evt[16] && !st.cfg[16].tsel |=> st.val[16] == $past(st.tmr[2].cnt))
    else $error("capture did not latch timer");
  a_cap_flag: assert property (
    cap_evt[17] |=> st.cfg[17].flag)
    else $error("capture did not set request flag");
  a_irq_gate: assert property (
    st.cfg[5].flag && st.cfg[5].ien |-> irq_req[5] ##0
    (!st.cfg[5].ien || !st.cfg[5].flag || irq_req[5]))
    else $error("enabled request not passed on");
  a_reload_ovf: assert property (
    ovf[1] |=> st.tmr[1].cnt == $past(st.tmr[1].rld) && st.ovfd[1])
    else $error("timer did not reload on overflow");
  a_count_up: assert property (
    tick[2] && st.tmr[2].cnt != `CCU_CNT_MAX
    |=> st.tmr[2].cnt == $past(st.tmr[2].cnt) + 16'h0001)
    else $error("timer did not advance by one");
  a_toggle_mode1: assert property (
    cmp_hit[1] && st.cfg[1].mode == ccu_pkg::CCU_CMP1
    |=> cc_pin_out[1] != $past(cc_pin_out[1]))
    else $error("mode 1 pin did not toggle");
  a_mode3_clear: assert property (
    st.cfg[4].mode == ccu_pkg::CCU_CMP3 && st.ovfd[{1'b0, st.cfg[4].tsel}]
    && !cmp_hit[4] |=> !cc_pin_out[4])
    else $error("mode 3 pin not cleared on overflow");
  a_mode2_once: assert property (
    st.cfg[3].mode == ccu_pkg::CCU_CMP2 && st.done[3]
    && !st.ovfd[{1'b0, st.cfg[3].tsel}] |=> $stable(st.cfg[3].flag) ||
    st.cfg[3].mode != ccu_pkg::CCU_CMP2 || $past(avs_write))
    else $error("mode 2 raised a second request");
  a_input_only: assert property (
    cc_pin_oe[27:24] == 4'h0 && cc_pin_out[27:24] == 4'h0)
    else $error("input-only channel drives its pin");
  a_presc_tick: assert property (
    tick[1] && st.tmr[1].ctl.src == `CCU_SRC_PRESC
    && st.tmr[1].ctl.psel == 3'h0 |-> st.pre[2:0] == 3'h7)
    else $error("divide by 8 tick misplaced");
  a_bus_wait: assert property (
    avs_read && !st.ack |-> avs_waitrequest ##1 (avs_read ? !avs_waitrequest : 1'b1))
    else $error("read not answered in one wait cycle");

  c_capture: cover property (cap_evt[16]);
  c_overflow: cover property (ovf[0]);
  c_mode3_set: cover property (
    cmp_hit[4] && st.cfg[4].mode == ccu_pkg::CCU_CMP3);
  c_double: cover property (
    cmp_hit[5] && st.cfg[5].mode == ccu_pkg::CCU_DBL);
endmodule

// >>> rtl/ccu_map.svh
// Purpose: constants of the dual capture/compare array
// Assumes: 20 MHz system clock, avalon byte addresses
// Notes:   all offsets are byte addresses of 32-bit words
// Notes on behaviour
// - two units, sixteen channels each
// - four 16-bit timers, each with reload
// - timer clock: prescaler or general timer overflow
// - first timer per unit takes external count
// - channel picks timer and capture or compare
// - each channel owns one pin
// - channels 24 to 27 never drive pins
// - capture copies assigned timer on pin event
// - capture raises the channel's request
// - capture edge: rising, falling or both
// - compare modes check equality on each timer tick
// - mode 0: request only, many per period
// - mode 1: pin toggles on each match
// - mode 2: request only, once per period
// - mode 3: set on match, clear on overflow
// - double mode: two registers toggle one pin on channels 0-7 and 16-23
// - select code 0 to 7 divides 8 to 1024
// - reload zero gives full 65536 step period
// - each first timer has its own external input bit
// - request flag set, passed on when enabled
// - general timer overflow can clock any of the four timers
`ifndef CCU_MAP_SVH
`define CCU_MAP_SVH
// register regions, byte offsets
`define CCU_CFG_BASE   10'h000
`define CCU_VAL_BASE   10'h080
`define CCU_CNT_BASE   10'h100
`define CCU_RLD_BASE   10'h110
`define CCU_TCTL_BASE  10'h120
`define CCU_PIN_ADDR   10'h130
// word index limits derived from the offsets
`define CCU_IDX_VAL    8'h20
`define CCU_IDX_CNT    8'h40
`define CCU_IDX_RLD    8'h44
`define CCU_IDX_TCTL   8'h48
`define CCU_IDX_PIN    8'h4c
// channel modes
`define CCU_MODE_OFF   3'h0
`define CCU_MODE_CAP   3'h1
`define CCU_MODE_CMP0  3'h2
`define CCU_MODE_CMP1  3'h3
`define CCU_MODE_CMP2  3'h4
`define CCU_MODE_CMP3  3'h5
`define CCU_MODE_DBL   3'h6
// timer clock sources
`define CCU_SRC_PRESC  2'h0
`define CCU_SRC_GEN    2'h1
`define CCU_SRC_EXT    2'h2
// prescaler base divide, timer end of range
`define CCU_PRESC_BASE 11'h008
`define CCU_CNT_MAX    16'hffff
// channels that may drive a pin (24..27 input only)
`define CCU_OUT_MASK   32'hf0ff_ffff
`define CCU_DBL_SPAN   8
`endif

// >>> rtl/ccu_pkg.sv
// Purpose: types of the dual capture/compare array
// Assumes: ccu_map.svh supplies all codes
// Notes:   packed layouts give the register bit order
`include "ccu_map.svh"
package ccu_pkg;
  typedef enum logic [2:0] {
    CCU_OFF  = `CCU_MODE_OFF,
    CCU_CAP  = `CCU_MODE_CAP,
    CCU_CMP0 = `CCU_MODE_CMP0,
    CCU_CMP1 = `CCU_MODE_CMP1,
    CCU_CMP2 = `CCU_MODE_CMP2,
    CCU_CMP3 = `CCU_MODE_CMP3,
    CCU_DBL  = `CCU_MODE_DBL
  } ccu_mode_e;
  // channel config: flag[7] ien[6] edge[5:4] tsel[3] mode[2:0]
  typedef struct packed {
    logic      flag;
    logic      ien;
    logic [1:0] edge_sel;
    logic      tsel;
    ccu_mode_e mode;
  } ccu_cfg_s;
  // timer control: run[5] src[4:3] psel[2:0]
  typedef struct packed {
    logic       run;
    logic [1:0] src;
    logic [2:0] psel;
  } ccu_tctl_s;
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rld;
    ccu_tctl_s   ctl;
  } ccu_tmr_s;
  typedef struct packed {
    ccu_cfg_s [31:0]       cfg;
    logic [31:0][15:0]     val;
    ccu_tmr_s [3:0]        tmr;
    logic [9:0]            pre;
    logic [31:0]           sync1;
    logic [31:0]           sync2;
    logic [31:0]           prev;
    logic [1:0]            ext_s1;
    logic [1:0]            ext_s2;
    logic [1:0]            ext_prev;
    logic [31:0]           pin;
    logic [31:0]           done;
    logic [3:0]            chg;
    logic [3:0]            ovfd;
    logic                  ack;
    logic [31:0]           rdata;
  } ccu_state_s;
endpackage

// >>> bench/ccu_pin_model.sv
// Purpose: far side of the ccu pins and count sources
// Assumes: tasks run just after a rising edge of clk_sys
// Notes:   a pin with its enable high carries the block's level
`timescale 1ns/1ps
module ccu_pin_model (
  // clock
  input  wire logic        clk_sys,
  // block pin outputs
  input  wire logic [31:0] cc_pin_out,
  input  wire logic [31:0] cc_pin_oe,
  // far-side levels
  output logic      [31:0] cc_pin_in,
  output logic      [1:0]  ext_count_in,
  output logic             gen_timer_ovf
);
  logic [31:0] drv = 32'h0000_0000;
  initial begin
    ext_count_in  = 2'b00;
    gen_timer_ovf = 1'b0;
  end
  // wire level: the block wins wherever it drives
  assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drv);
  // slow pulses so the input synchroniser sees each one once
  task automatic ext_pulse(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge clk_sys) ext_count_in <= m;
      repeat (4) @(posedge clk_sys);
      ext_count_in <= 2'b00;
      repeat (4) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  // one-cycle overflow pulses of the general timer
  task automatic gen_pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys) gen_timer_ovf <= 1'b1;
      @(posedge clk_sys) gen_timer_ovf <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
  endtask
  // capture pin level
  task automatic pin_set(input int ch, input logic v);
    @(posedge clk_sys) drv[ch] <= v;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// >>> bench/ccu_tb_top.sv
// Purpose: self-checking bench of the capture/compare array
// Assumes: the bus master waits for waitrequest low, at most 20 cycles
// Notes:   bus answers are taken at the rising edge that ends the wait
`timescale 1ns/1ps
`include "ccu_map.svh"
module ccu_tb_top;
  logic        clk_sys;
  logic        rst;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  lanes;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        gen_timer_ovf;
  logic [1:0]  ext_count_in;
  logic [31:0] cc_pin_in;
  logic [31:0] cc_pin_out;
  logic [31:0] cc_pin_oe;
  logic [31:0] irq_req;
  logic [31:0] rd;
  logic [15:0] lfsr;
  logic [15:0] exp_t;
  logic [15:0] t_a;
  int          bad_count;
  int          comparisons;
  ccu_top dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(lanes),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gen_timer_ovf(gen_timer_ovf), .ext_count_in(ext_count_in),
    .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
    .cc_pin_oe(cc_pin_oe), .irq_req(irq_req));
  ccu_pin_model far (.clk_sys(clk_sys), .cc_pin_out(cc_pin_out),
    .cc_pin_oe(cc_pin_oe), .cc_pin_in(cc_pin_in),
    .ext_count_in(ext_count_in), .gen_timer_ovf(gen_timer_ovf));
  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      summarize();
    end
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input string nm, input logic [9:0] a,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {1'b0, v[15:1]} ^ (v[0] ? 16'hb400 : 16'h0000);
  endfunction
  function automatic logic [31:0] cfg_w(input logic ien,
      input logic [1:0] e, input ccu_pkg::ccu_mode_e m);
    ccu_pkg::ccu_cfg_s c;
    c = '{flag: 1'b0, ien: ien, edge_sel: e, tsel: 1'b0, mode: m};
    return {24'h00_0000, c};
  endfunction
  // fewest ticks expected in 2048 cycles at select code s
  function automatic logic [15:0] div_lo(input int s);
    return 16'(2048 >> (s + 3));
  endfunction
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end
  initial begin
    ccu_pkg::ccu_mode_e md[5];
    md = '{ccu_pkg::CCU_CMP1, ccu_pkg::CCU_CMP0, ccu_pkg::CCU_CMP2,
           ccu_pkg::CCU_CMP3, ccu_pkg::CCU_DBL};
    rst = 1'b1;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    lanes = 4'hf;
    lfsr = 16'h7623;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk("cfg_rst", `CCU_CFG_BASE + 10'h014, 32'h0000_0000);
    rd_chk("tctl_rst", `CCU_TCTL_BASE + 10'h00c, 32'h0000_0000);
    chk("irq_rst", irq_req, 32'h0000_0000);
    bus(1'b1, 10'h134, 32'hffff_ffff);
    rd_chk("unmapped", 10'h134, 32'h0000_0000);
    lanes <= 4'h1;
    bus(1'b1, `CCU_VAL_BASE + 10'h050, 32'h0000_abcd);
    lanes <= 4'hf;
    rd_chk("lane", `CCU_VAL_BASE + 10'h050, 32'h0000_00cd);
    // five compare modes on the first timer, stepped externally
    bus(1'b1, `CCU_TCTL_BASE, 32'h0000_0030);
    for (int c = 1; c <= 5; c++) begin
      bus(1'b1, `CCU_VAL_BASE + 10'(4 * c), 32'h0000_0003);
      bus(1'b1, `CCU_CFG_BASE + 10'(4 * c), cfg_w(1'b1, 2'b00, md[c-1]));
    end
    bus(1'b1, `CCU_VAL_BASE + 10'h034, 32'h0000_0004);
    bus(1'b1, `CCU_VAL_BASE + 10'h060, 32'h0000_0003);
    bus(1'b1, `CCU_CFG_BASE + 10'h060, cfg_w(1'b0, 2'b00, md[0]));
    far.ext_pulse(2'b01, 3);
    chk("pins_m3", cc_pin_out[5:1], 32'h0000_0019);
    chk("oe", {cc_pin_oe[24], cc_pin_oe[5:1]}, 32'h0000_0019);
    chk("irq_m3", irq_req[3:2], 32'h0000_0003);
    far.ext_pulse(2'b01, 1);
    chk("pins_m4", cc_pin_out[5:1], 32'h0000_0009);
    rd_chk("pin_reg", `CCU_PIN_ADDR, 32'h0000_0012);
    bus(1'b1, `CCU_CFG_BASE + 10'h008, cfg_w(1'b1, 2'b00, md[1]));
    bus(1'b1, `CCU_CFG_BASE + 10'h00c, cfg_w(1'b1, 2'b00, md[2]));
    bus(1'b1, `CCU_CNT_BASE, 32'h0000_0002);
    far.ext_pulse(2'b01, 1);
    chk("pins_again", cc_pin_out[5:1], 32'h0000_0018);
    chk("irq_again", irq_req[3:2], 32'h0000_0001);
    bus(1'b1, `CCU_CNT_BASE, 32'h0000_ffff);
    far.ext_pulse(2'b01, 1);
    chk("pin_ovf", cc_pin_out[4], 32'h0000_0000);
    rd_chk("cnt_wrap", `CCU_CNT_BASE, 32'h0000_0000);
    chk("in_only", cc_pin_out[27:24], 32'h0000_0000);
    // captures in the second unit: rising, falling, both
    bus(1'b1, `CCU_TCTL_BASE + 10'h008, 32'h0000_0030);
    bus(1'b1, `CCU_CNT_BASE, 32'h0000_0000);
    bus(1'b1, `CCU_CNT_BASE + 10'h008, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `CCU_CFG_BASE + 10'(64 + 4 * i),
          cfg_w(1'b1, 2'(i + 1), ccu_pkg::CCU_CAP));
    end
    exp_t = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      exp_t = exp_t + 16'(lfsr[2:0]) + 16'h0001;
      far.ext_pulse(2'b11, int'(lfsr[2:0]) + 1);
      far.pin_set(16 + i, 1'b1);
      chk("cap_rise", irq_req[16+i], i != 1);
      far.pin_set(16 + i, 1'b0);
      chk("cap_flag", irq_req[16+i], 32'h0000_0001);
      rd_chk("cap_val", `CCU_VAL_BASE + 10'(64 + 4 * i), {16'h0000, exp_t});
    end
    rd_chk("lockstep", `CCU_CNT_BASE, {16'h0000, exp_t});
    // general timer overflow as count source, then a reload
    bus(1'b1, `CCU_TCTL_BASE + 10'h00c, 32'h0000_0028);
    lfsr = lfsr_next(lfsr);
    far.gen_pulse(int'(lfsr[3:0]) + 1);
    rd_chk("gen_cnt", `CCU_CNT_BASE + 10'h00c, 32'(lfsr[3:0]) + 1);
    bus(1'b1, `CCU_RLD_BASE + 10'h00c, 32'h0000_fff0);
    bus(1'b1, `CCU_CNT_BASE + 10'h00c, 32'h0000_ffff);
    far.gen_pulse(1);
    rd_chk("reload", `CCU_CNT_BASE + 10'h00c, 32'h0000_fff0);
    // every prescaler code on the second timer of the first unit
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, `CCU_TCTL_BASE + 10'h004, {26'h000_0000, 3'b100, 3'(s)});
      bus(1'b0, `CCU_CNT_BASE + 10'h004, 32'h0000_0000);
      t_a = rd[15:0];
      repeat (2048) @(posedge clk_sys);
      bus(1'b0, `CCU_CNT_BASE + 10'h004, 32'h0000_0000);
      t_a = rd[15:0] - t_a;
      chk("presc", t_a >= div_lo(s) && t_a <= div_lo(s) + 1, 32'h0000_0001);
    end
    summarize();
  end
endmodule
